//--- src/pops_top.sv
// Purpose: Path overhead status, event latches and pointer readback.
// Assumes: Inputs are synchronous to pclk; events are one-cycle pulses.
// Notes:   Reads take one wait state so read data comes from flops.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module pops_top #(
  parameter int unsigned ADDR_WIDTH = 12  // APB address width
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_WIDTH-1:0]     paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire pops_pkg::pops_events_type path_events,
  input  wire pops_pkg::pops_levels_type path_levels,
  output logic                           interrupt_out_n
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      rd_data;       // Captured read byte
    logic            ack;           // Answer pending this access
    logic            err;           // Unmapped address flag
    logic            ctrl_reserved; // Reserved status bit
    logic            newptr_en;     // New pointer enable
    logic            newptr_latch;  // New pointer latch
    logic [7:0]      alarm_latch;   // Alarm event latches
    logic [7:0]      ptr_latch;     // Pointer event latches
    logic [7:0]      alarm_en;      // Alarm enables
    logic [7:0]      ptr_en;        // Pointer enables
    logic            filter_ten;    // Ten-frame filter select
    logic [1:0]      filt;          // Filtered RDI (0), aux RDI (1)
    logic [1:0]      cand;          // Value of current G1 run
    logic [1:0][3:0] run;           // Length of current G1 run
    logic [7:0]      label;         // Accepted signal label
    logic [7:0]      last_c2;       // C2 of previous frame
    logic            lop_q;         // Pointer loss, last cycle
    logic            ais_q;         // AIS, last cycle
  } pops_state_type;

  pops_state_type st;       // Registered state
  pops_state_type next_st;  // Next state

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Word index of the byte address; lane bits 1:0 below are ignored
  function automatic logic [7:0] word_index(input logic [ADDR_WIDTH-1:0] a);
    word_index = a[9:2];
  endfunction

  // Whether an index names one of our seven registers
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx >= pops_pkg::IDX_STATUS_CONTROL) && (idx <= pops_pkg::IDX_PTR_HIGH)
                && (paddr[ADDR_WIDTH-1:10] == '0) && (paddr[1:0] == 2'b00);
  endfunction

  logic [7:0] idx;         // Decoded index
  logic       access;      // Access phase seen
  logic       complete;    // Transfer ends at this edge
  logic [7:0] read_mux;    // Byte to capture for a read
  logic [1:0] g1_bits;     // Raw G1 bits by filter slot
  logic [3:0] threshold;   // Frames needed for filter
  logic [3:0] run_next;    // Scratch run length
  logic [7:0] alarm_set;   // Alarm events this cycle
  logic [7:0] ptr_set;     // Pointer events this cycle
  logic [7:0] alarm_clr;   // Alarm bits cleared by read
  logic [7:0] ptr_clr;     // Pointer bits cleared by read
  logic       newptr_clr;  // New pointer bit cleared by read
  logic       wr_lane;     // Low byte lane written

  assign idx      = word_index(paddr);
  assign access   = psel && penable;
  assign complete = access && st.ack && clk_en;
  assign wr_lane  = complete && pwrite && !st.err && pstrb[0];

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  // Unused bits read zero
  always_comb
  begin
    read_mux = 8'h00;
    case (idx)
      pops_pkg::IDX_STATUS_CONTROL:
      begin
        read_mux[pops_pkg::STAT_RESERVED] = st.ctrl_reserved;
        read_mux[pops_pkg::STAT_LOP]      = path_levels.pointer_loss_alarm;
        read_mux[pops_pkg::STAT_AIS]      = path_levels.path_ais_alarm;
        read_mux[pops_pkg::STAT_RDI]      = st.filt[0];
        read_mux[pops_pkg::STAT_NEWPTR_L] = st.newptr_latch;
        read_mux[pops_pkg::STAT_NEWPTR_E] = st.newptr_en;
      end
      pops_pkg::IDX_ALARM_LATCHES: read_mux = st.alarm_latch;
      pops_pkg::IDX_PTR_LATCHES:   read_mux = st.ptr_latch;
      pops_pkg::IDX_ALARM_ENABLES: read_mux = st.alarm_en;
      pops_pkg::IDX_PTR_ENABLES:   read_mux = st.ptr_en;
      pops_pkg::IDX_PTR_LOW:       read_mux = path_levels.current_pointer_value[7:0];
      pops_pkg::IDX_PTR_HIGH:
      begin
        read_mux[pops_pkg::PH_FILTER]    = st.filter_ten;
        read_mux[pops_pkg::PH_SIZE_HIGH] = path_levels.size_bit_high;
        read_mux[pops_pkg::PH_SIZE_LOW]  = path_levels.size_bit_low;
        read_mux[pops_pkg::PH_PTR_MSB -: 2] = path_levels.current_pointer_value[9:8];
      end
      default: read_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------
  // Clears use the captured byte, so an event landing between capture
  // and completion survives the read
  always_comb
  begin
    alarm_set = 8'h00;
    ptr_set   = 8'h00;
    alarm_set[pops_pkg::AL_FEBE] = path_events.far_end_error;
    alarm_set[pops_pkg::AL_BIP]  = path_events.bip_error;
    alarm_set[pops_pkg::AL_AIS]  = path_levels.path_ais_alarm != st.ais_q;
    alarm_set[pops_pkg::AL_LOP]  = path_levels.pointer_loss_alarm != st.lop_q;
    ptr_set[pops_pkg::PL_NDF]    = path_events.ndf_valid;
    ptr_set[pops_pkg::PL_PSE]    = path_events.pos_stuff;
    ptr_set[pops_pkg::PL_NSE]    = path_events.neg_stuff;
    ptr_set[pops_pkg::PL_ILLPTR] = path_events.illegal_ptr;
    ptr_set[pops_pkg::PL_INVNDF] = path_events.invalid_ndf;
    ptr_set[pops_pkg::PL_DISC]   = path_events.discont_ptr;
    ptr_set[pops_pkg::PL_ILLJ]   = path_events.illegal_just;
    alarm_clr  = 8'h00;
    ptr_clr    = 8'h00;
    newptr_clr = 1'b0;
    if (complete && !pwrite && !st.err)
    begin
      if (idx == pops_pkg::IDX_ALARM_LATCHES) alarm_clr = st.rd_data;
      if (idx == pops_pkg::IDX_PTR_LATCHES)   ptr_clr   = st.rd_data;
      if (idx == pops_pkg::IDX_STATUS_CONTROL) newptr_clr = st.rd_data[pops_pkg::STAT_NEWPTR_L];
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st   = st;
    run_next  = 4'h0;
    g1_bits   = {path_levels.g1_aux_rdi, path_levels.g1_rdi};
    threshold = st.filter_ten ? pops_pkg::FILTER_LONG_FRAMES
                              : pops_pkg::FILTER_SHORT_FRAMES;
    // Bus: capture in first access cycle, answer in the next
    if (access && !st.ack)
    begin
      next_st.ack     = 1'b1;
      next_st.err     = !is_mapped(idx);
      // Refused or write transfers return zero, never a stale byte
      next_st.rd_data = (pwrite || !is_mapped(idx)) ? 8'h00 : read_mux;
    end
    else if (complete)
    begin
      next_st.ack = 1'b0;
      next_st.err = 1'b0;
    end
    // Register writes, reserved bits stored as written
    if (wr_lane)
    begin
      case (idx)
        pops_pkg::IDX_STATUS_CONTROL:
        begin
          next_st.ctrl_reserved = pwdata[pops_pkg::STAT_RESERVED];
          next_st.newptr_en     = pwdata[pops_pkg::STAT_NEWPTR_E];
        end
        pops_pkg::IDX_ALARM_ENABLES: next_st.alarm_en   = pwdata[7:0];
        pops_pkg::IDX_PTR_ENABLES:   next_st.ptr_en     = pwdata[7:0];
        pops_pkg::IDX_PTR_HIGH:      next_st.filter_ten = pwdata[pops_pkg::PH_FILTER];
        default:                     next_st.ctrl_reserved = st.ctrl_reserved;
      endcase
    end
    // Alarm edge history
    next_st.lop_q = path_levels.pointer_loss_alarm;
    next_st.ais_q = path_levels.path_ais_alarm;
    // Frame-rate filters for G1 bits and C2 label
    if (path_events.frame_tick)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (g1_bits[i] == st.cand[i])
          run_next = (st.run[i] < pops_pkg::FILTER_LONG_FRAMES) ? st.run[i] + 4'h1 : st.run[i];
        else
          run_next = pops_pkg::FILTER_COUNT_ONE;
        next_st.cand[i] = g1_bits[i];
        next_st.run[i]  = run_next;
        if (run_next >= threshold)
          next_st.filt[i] = g1_bits[i];
      end
      next_st.last_c2 = path_levels.c2_label;
      if (path_levels.c2_label == st.last_c2)
        next_st.label = path_levels.c2_label;
    end
    // Latches: set wins over clear
    next_st.alarm_latch = (st.alarm_latch & ~alarm_clr) | alarm_set;
    next_st.alarm_latch[pops_pkg::AL_RDI] = (st.alarm_latch[pops_pkg::AL_RDI] & ~alarm_clr[pops_pkg::AL_RDI])
                                            | (next_st.filt != st.filt);
    next_st.alarm_latch[pops_pkg::AL_PSL] = (st.alarm_latch[pops_pkg::AL_PSL] & ~alarm_clr[pops_pkg::AL_PSL])
                                            | (next_st.label != st.label);
    next_st.ptr_latch    = (st.ptr_latch & ~ptr_clr) | ptr_set;
    next_st.newptr_latch = (st.newptr_latch & ~newptr_clr) | path_events.new_pointer;
  end

  // ---------------------------------------------------------------
  // State register, frozen while clk_en is low
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st          <= '0;
      st.alarm_en <= pops_pkg::ENABLES_RESET;
      st.ptr_en   <= pops_pkg::ENABLES_RESET;
    end
    else if (clk_en)
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata  = {24'h000000, st.rd_data};
  assign pready  = st.ack && clk_en;
  assign pslverr = st.ack && clk_en && st.err;
  // Active low while any enabled latch is set
  assign interrupt_out_n = !((st.newptr_latch && st.newptr_en)
                             || |(st.alarm_latch & st.alarm_en)
                             || |(st.ptr_latch & st.ptr_en));

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completion edge of a mapped read of index i
  sequence s_read_done(logic [7:0] i);
    complete && !pwrite && !st.err && idx == i;
  endsequence

  // Capture edge of a read of index i, where the byte is flopped
  sequence s_capture(logic [7:0] i);
    clk_en && access && !st.ack && !pwrite && idx == i;
  endsequence

  // Nothing sets an alarm latch this cycle, since a set would win
  sequence s_alarm_quiet;
    alarm_set == 8'h00 && next_st.filt == st.filt && next_st.label == st.label;
  endsequence

  // Latch setting on events, and the new pointer interrupt
  a_newptr_irq: assert property (st.newptr_latch && st.newptr_en |-> !interrupt_out_n)
    else $error("new pointer interrupt missing");
  a_newptr_set: assert property (clk_en && path_events.new_pointer |=> st.newptr_latch)
    else $error("new pointer latch not set");
  a_bip_set: assert property (clk_en && path_events.bip_error |=> st.alarm_latch[pops_pkg::AL_BIP])
    else $error("parity latch not set");
  a_far_end_set: assert property (clk_en && path_events.far_end_error |=> st.alarm_latch[pops_pkg::AL_FEBE])
    else $error("far-end latch not set");
  a_rdi_change: assert property (clk_en && next_st.filt != st.filt |=> st.alarm_latch[pops_pkg::AL_RDI])
    else $error("remote defect change not latched");
  a_ais_change: assert property (clk_en && $changed(path_levels.path_ais_alarm) && $past(clk_en)
    |=> st.alarm_latch[pops_pkg::AL_AIS])
    else $error("AIS change not latched");
  a_loss_change: assert property (clk_en && $changed(path_levels.pointer_loss_alarm) && $past(clk_en)
    |=> st.alarm_latch[pops_pkg::AL_LOP])
    else $error("pointer loss change not latched");
  a_label_change: assert property (clk_en && next_st.label != st.label |=> st.alarm_latch[pops_pkg::AL_PSL])
    else $error("label change not latched");
  a_ptr_event: assert property (clk_en && path_events.discont_ptr |=> st.ptr_latch[pops_pkg::PL_DISC])
    else $error("pointer event not latched");

  // Read clears
  a_read_clear: assert property (s_read_done(pops_pkg::IDX_ALARM_LATCHES) ##0 s_alarm_quiet
    |=> st.alarm_latch == 8'h00)
    else $error("alarm read did not clear");
  a_ptr_clear: assert property (s_read_done(pops_pkg::IDX_PTR_LATCHES) ##0 (ptr_set == 8'h00)
    |=> st.ptr_latch == 8'h00)
    else $error("pointer read did not clear");

  // Interrupt output against latches and enables
  a_irq_level: assert property (st.alarm_latch == 8'h00 && st.ptr_latch == 8'h00 && !st.newptr_latch
    |-> interrupt_out_n)
    else $error("interrupt without latch");
  a_enable_gate: assert property ((st.alarm_latch & st.alarm_en) == 8'h00
    && (st.ptr_latch & st.ptr_en) == 8'h00 && !(st.newptr_latch && st.newptr_en) |-> interrupt_out_n)
    else $error("disabled latch raised interrupt");
  a_ndf_irq: assert property (st.ptr_latch[pops_pkg::PL_NDF] && st.ptr_en[pops_pkg::PL_NDF]
    |-> !interrupt_out_n)
    else $error("NDF interrupt missing");

  // Frame filters; a premature update would show as a moved status
  a_filter_hold: assert property (clk_en && path_events.frame_tick && st.run[0] < 4'h4
    && g1_bits[0] != st.filt[0] |=> st.filt[0] == $past(st.filt[0]))
    else $error("filter updated too early");
  a_filter_long: assert property (clk_en && path_events.frame_tick && st.filter_ten && st.run[0] < 4'h9
    && g1_bits[0] != st.filt[0] |=> st.filt[0] == $past(st.filt[0]))
    else $error("long filter updated too early");
  a_label_hold: assert property (clk_en && path_events.frame_tick && path_levels.c2_label != st.last_c2
    |=> st.label == $past(st.label))
    else $error("label accepted after one frame");

  // Captured read bytes
  a_live_lop: assert property (s_capture(pops_pkg::IDX_STATUS_CONTROL)
    |=> st.rd_data[pops_pkg::STAT_LOP] == $past(path_levels.pointer_loss_alarm))
    else $error("pointer loss status not live");
  a_live_ais: assert property (s_capture(pops_pkg::IDX_STATUS_CONTROL)
    |=> st.rd_data[pops_pkg::STAT_AIS] == $past(path_levels.path_ais_alarm))
    else $error("AIS status not live");
  a_ptr_low: assert property (s_capture(pops_pkg::IDX_PTR_LOW)
    |=> st.rd_data == $past(path_levels.current_pointer_value[7:0]))
    else $error("pointer low byte wrong");
  a_ptr_high: assert property (s_capture(pops_pkg::IDX_PTR_HIGH)
    |=> st.rd_data[pops_pkg::PH_PTR_MSB -: 2] == $past(path_levels.current_pointer_value[9:8]))
    else $error("pointer high bits wrong");
  a_size_bits: assert property (s_capture(pops_pkg::IDX_PTR_HIGH)
    |=> st.rd_data[pops_pkg::PH_SIZE_HIGH] == $past(path_levels.size_bit_high)
        && st.rd_data[pops_pkg::PH_SIZE_LOW] == $past(path_levels.size_bit_low))
    else $error("size bits wrong");
  // Refused transfers must not leak a register byte
  a_refused_zero: assert property (clk_en && access && !st.ack && !is_mapped(idx)
    |=> st.rd_data == 8'h00)
    else $error("refused read returned data");

endmodule // pops_top

//--- src/pops_pkg.sv
// Purpose: Constants and carriers for the path overhead status bank.
// Assumes: Registers are 8 bits wide, one per aligned 32-bit APB word.
// Notes:   Byte address of a register is four times its index.
package pops_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS_CONTROL = 8'h30; // Status and control
  localparam logic [7:0] IDX_ALARM_LATCHES  = 8'h31; // Alarm event latches
  localparam logic [7:0] IDX_PTR_LATCHES    = 8'h32; // Pointer event latches
  localparam logic [7:0] IDX_ALARM_ENABLES  = 8'h33; // Alarm event enables
  localparam logic [7:0] IDX_PTR_ENABLES    = 8'h34; // Pointer event enables
  localparam logic [7:0] IDX_PTR_LOW        = 8'h35; // Pointer bits 7..0
  localparam logic [7:0] IDX_PTR_HIGH       = 8'h36; // Pointer high and filter

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STAT_RESERVED = 7; // Reserved read/write
  localparam int STAT_LOP      = 5; // Pointer loss level
  localparam int STAT_AIS      = 3; // Path AIS level
  localparam int STAT_RDI      = 2; // Filtered remote defect
  localparam int STAT_NEWPTR_L = 1; // New pointer latch
  localparam int STAT_NEWPTR_E = 0; // New pointer enable
  localparam int AL_FEBE       = 0; // Far-end error
  localparam int AL_BIP        = 1; // Parity error
  localparam int AL_RDI        = 2; // Remote defect change
  localparam int AL_AIS        = 3; // AIS change
  localparam int AL_LOP        = 5; // Pointer loss change
  localparam int AL_PSL        = 7; // Signal label change
  localparam int PL_NDF        = 0; // New data flag
  localparam int PL_PSE        = 1; // Positive stuff
  localparam int PL_NSE        = 2; // Negative stuff
  localparam int PL_ILLPTR     = 3; // Illegal pointer
  localparam int PL_INVNDF     = 4; // Invalid NDF
  localparam int PL_DISC       = 5; // Discontinuous pointer
  localparam int PL_ILLJ       = 7; // Illegal justification
  localparam int PH_FILTER     = 5; // Ten-frame filter select
  localparam int PH_SIZE_HIGH  = 3; // Size bit high
  localparam int PH_SIZE_LOW   = 2; // Size bit low
  localparam int PH_PTR_MSB    = 1; // Pointer bit 9 position

  // ---------------------------------------------------------------
  // Reset values and frame counts
  // ---------------------------------------------------------------
  localparam logic [7:0] ENABLES_RESET      = 8'h00; // All enables off
  localparam logic [3:0] FILTER_LONG_FRAMES  = 4'hA;  // Ten frames
  localparam logic [3:0] FILTER_SHORT_FRAMES = 4'h5;  // Five frames
  localparam logic [3:0] FILTER_COUNT_ONE    = 4'h1;  // First frame of a run

  // ---------------------------------------------------------------
  // Carriers from the pointer interpreter and overhead extractor
  // ---------------------------------------------------------------
  typedef struct packed {
    logic frame_tick;     // One pulse per received frame
    logic new_pointer;    // New pointer indication
    logic bip_error;      // Path BIP-8 error detected
    logic far_end_error;  // Path FEBE detected
    logic ndf_valid;      // NDF to a valid pointer
    logic pos_stuff;      // Positive stuff event
    logic neg_stuff;      // Negative stuff event
    logic illegal_ptr;    // Illegal pointer
    logic invalid_ndf;    // Invalid NDF
    logic discont_ptr;    // Discontinuous pointer change
    logic illegal_just;   // Illegal justification request
  } pops_events_type;

  typedef struct packed {
    logic       pointer_loss_alarm;    // Loss of pointer state
    logic       path_ais_alarm;        // Path AIS state
    logic       g1_rdi;                // Raw G1 remote defect bit
    logic       g1_aux_rdi;            // Raw G1 auxiliary bit
    logic [7:0] c2_label;              // Raw C2 byte this frame
    logic [9:0] current_pointer_value; // Pointer from H1/H2
    logic       size_bit_high;         // Last H1 size bit high
    logic       size_bit_low;          // Last H1 size bit low
  } pops_levels_type;

endpackage

//--- verif/pops_src_model.sv
// Purpose: Far-side source of path events and alarm levels.
// Assumes: Bench requests change just after a rising pclk edge.
// Notes:   Events leave one clock after their requests; levels follow requests.
`timescale 1ns/10ps
module pops_src_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire pops_pkg::pops_events_type ev_req,
  input  wire pops_pkg::pops_levels_type lv_req,
  output pops_pkg::pops_events_type      path_events,
  output pops_pkg::pops_levels_type      path_levels
);
  // Register requests; each output lasts as long as its request, one clock later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      path_events <= '0; // Quiet while in reset
      path_levels <= '0; // No alarms, label zero
    end
    else
    begin
      path_events <= ev_req; // One pulse per request cycle
      path_levels <= lv_req; // Levels track the request
    end
  end
endmodule // pops_src_model

//--- verif/tb.sv
// Purpose: Self-checking bench for the path overhead status bank.
// Assumes: One wait state per APB transfer; clk_en held high.
// Notes:   Byte address is four times the register index.
`timescale 1ns/10ps
module tb;
  logic                      pclk;        // 200 MHz clock
  logic                      presetn;     // Async reset, active low
  logic                      psel;        // APB select
  logic                      penable;     // APB access phase
  logic                      pwrite;      // APB direction
  logic [11:0]               paddr;       // APB byte address
  logic [31:0]               pwdata;      // APB write data
  logic [31:0]               prdata;      // APB read data
  logic                      pready;      // APB done
  logic                      pslverr;     // APB error
  logic                      irq_n;       // Interrupt, active low
  pops_pkg::pops_events_type ev;          // Event requests
  pops_pkg::pops_levels_type lv;          // Level requests
  pops_pkg::pops_events_type path_events; // Events into the bank
  pops_pkg::pops_levels_type path_levels; // Levels into the bank
  int                        err_total;   // Mismatches
  int                        n_tests;     // Comparisons

  pops_src_model u_src (.pclk(pclk), .presetn(presetn), .ev_req(ev), .lv_req(lv),
    .path_events(path_events), .path_levels(path_levels));
  pops_top #(.ADDR_WIDTH(12)) u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .path_events(path_events), .path_levels(path_levels), .interrupt_out_n(irq_n));

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Checks, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One transfer; bounded wait on pready, one idle edge after release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd_data, output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      print_verdict();
    end
    rd_data = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  // Masked read compare; upper lanes must read zero
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("reg %h", a), {24'h0, exp & m}, r & {24'hFFFFFF, m});
  endtask

  task automatic pulse(input logic [10:0] bits);
    ev <= pops_pkg::pops_events_type'(bits);
    @(posedge pclk);
    ev <= '0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic frames(input int n);
    repeat (n) pulse(11'h400);
  endtask

  task automatic irq(input logic x);
    chk("interrupt_out_n", {31'h0, x}, {31'h0, irq_n});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic        er;
    err_total = 0;
    n_tests = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ev = '0;
    lv = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h0CC, 8'h00, 8'hFF);
    rd(12'h0D0, 8'h00, 8'hFF);
    apb(1'b0, 12'h0E0, 32'h0, r, er);
    chk("unmapped pslverr", 32'h1, {31'h0, er});
    wr(12'h0CC, 8'hAF);
    wr(12'h0D0, 8'hBF);
    rd(12'h0CC, 8'hAF, 8'hFF);
    rd(12'h0D0, 8'hBF, 8'hFF);
    // Parity plus far-end error pulses
    pulse(11'h180);
    irq(1'b0);
    rd(12'h0C4, 8'h03, 8'hFF);
    irq(1'b1);
    rd(12'h0C4, 8'h00, 8'hFF);
    // Pointer loss and AIS: rising then falling
    lv.pointer_loss_alarm <= 1'b1;
    lv.path_ais_alarm <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(12'h0C0, 8'h28, 8'h28);
    rd(12'h0C4, 8'h28, 8'hFF);
    lv.pointer_loss_alarm <= 1'b0;
    lv.path_ais_alarm <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(12'h0C0, 8'h00, 8'h28);
    rd(12'h0C4, 8'h28, 8'hFF);
    // All pointer events; pointer read bracketed by latch reads
    lv.current_pointer_value <= 10'h2A5;
    lv.size_bit_high <= 1'b1;
    pulse(11'h07F);
    irq(1'b0);
    rd(12'h0C8, 8'hBF, 8'hFF);
    rd(12'h0D4, 8'hA5, 8'hFF);
    rd(12'h0D8, 8'h0A, 8'h0F);
    rd(12'h0C8, 8'h00, 8'hFF);
    irq(1'b1);
    // Only the flag enable left on among the pointer enables
    wr(12'h0D0, 8'h01);
    pulse(11'h040);
    irq(1'b0);
    rd(12'h0C8, 8'h01, 8'hFF);
    pulse(11'h020);
    irq(1'b1);
    rd(12'h0C8, 8'h02, 8'hFF);
    // New pointer, gated off then on
    pulse(11'h200);
    irq(1'b1);
    rd(12'h0C0, 8'h02, 8'h03);
    wr(12'h0C0, 8'h01);
    pulse(11'h200);
    irq(1'b0);
    rd(12'h0C0, 8'h03, 8'h03);
    irq(1'b1);
    // Remote defect filter, five then ten frames
    lv.g1_rdi <= 1'b1;
    frames(4);
    rd(12'h0C0, 8'h00, 8'h04);
    frames(1);
    rd(12'h0C0, 8'h04, 8'h04);
    rd(12'h0C4, 8'h04, 8'h04);
    wr(12'h0D8, 8'h20);
    rd(12'h0D8, 8'h20, 8'h20);
    lv.g1_rdi <= 1'b0;
    frames(9);
    rd(12'h0C0, 8'h04, 8'h04);
    frames(1);
    rd(12'h0C0, 8'h00, 8'h04);
    // Signal label needs two equal frames
    lv.c2_label <= 8'h13;
    frames(1);
    rd(12'h0C4, 8'h00, 8'h80);
    frames(1);
    rd(12'h0C4, 8'h80, 8'h80);
    print_verdict();
  end
endmodule // tb
